// file: hdl/wpt_timer.sv
// Watchdog and power-fail timer core with register port
`timescale 1ns/100ps
module wpt_timer import wpt_pkg::*; #(
  parameter int DIV1 = TICK1_CYC,
  parameter int DIV2 = TICK2_CYC,
  parameter int DIV3 = TICK3_CYC,
  parameter int PULSE_MAX = PULSE_MAX_CYC,
  parameter logic [7:0] DEF1 = DEF_PRE1,
  parameter logic [7:0] DEF2 = DEF_PRE2,
  parameter logic [7:0] DEF3 = DEF_PRE3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic start_detect,
  input wire logic on_battery,
  output logic timer_irq_n
);
  wpt_state_s s; // Registered state
  wpt_state_s next_s; // Next state
  wpt_bus_s bus; // Bundled bus request
  logic bat; // Synchronised battery level
  logic tick; // Timer rate enable
  logic [7:0] pre_lim; // Effective prescale terminal
  logic ovf; // Prescale overflow this cycle
  logic en_rise; // Enable just set
  logic bat_rise; // Entry into battery mode
  logic bat_fall; // Return to main supply
  logic flag_clr; // Software clears flag
  logic flag_set; // Hardware sets flag
  logic wd_act; // Watchdog running
  logic pf_act; // Power fail counting
  logic [PULSE_W-1:0] pmax; // Pulse limit in cycles

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign pmax = PULSE_W'(PULSE_MAX - 1);

  // Battery pin crosses into clk domain
  wpt_sync2 u_bat_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din(on_battery),
    .dout(bat)
  );

  // Tick at rate chosen by clock select
  wpt_tick_gen #(
    .DIV1(DIV1),
    .DIV2(DIV2),
    .DIV3(DIV3)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .sel(s.ctrl.tcs),
    .tick(tick)
  );

  // Prescale terminal: target or per-rate default
  always_comb begin
    if (s.pre_target != 8'h00) begin
      pre_lim = s.pre_target; // RQ20
    end else begin
      unique case (s.ctrl.tcs)
        2'h1: pre_lim = DEF1; // RQ21 RQ11
        2'h2: pre_lim = DEF2; // RQ21
        2'h3: pre_lim = DEF3; // RQ21
        default: pre_lim = ONE;
      endcase
    end
  end

  // Event decode
  assign en_rise = s.ctrl.en && !s.en_q;
  assign bat_rise = bat && !s.bat_q;
  assign bat_fall = !bat && s.bat_q;
  assign flag_clr = bus.wr && bus.addr == OFS_STATUS && !bus.wdata[STS_FLAG];
  assign wd_act = s.ctrl.en && s.ctrl.mode == WPT_WATCHDOG && s.wd_ok &&
                  s.ctrl.tcs != TCS_OFF && !en_rise; // RQ3
  // Count only while the synced battery level is still high, so the
  // cycle of the return to main supply cannot bump a held count
  assign pf_act = s.ctrl.en && s.ctrl.mode == WPT_POWERFAIL && s.pf_run && bat &&
                  !s.pf_done && s.ctrl.tcs != TCS_OFF; // RQ4 RQ12 RQ16
  assign ovf = tick && s.pre_count >= pre_lim;

  // Next state of the whole block
  always_comb begin
    next_s = s;
    flag_set = 1'b0;
    next_s.en_q = s.ctrl.en;
    next_s.bat_q = bat;
    // Register writes
    if (bus.wr) begin
      unique case (bus.addr)
        OFS_CTRL: next_s.ctrl = wpt_ctrl_s'(bus.wdata[5:0]);
        OFS_TARGET: next_s.target = bus.wdata;
        OFS_PRESCALE: next_s.pre_target = bus.wdata;
        default: ;
      endcase
    end
    // Register reads, data in following cycle
    next_s.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        OFS_CTRL: next_s.rdata = {2'h0, s.ctrl};
        OFS_TARGET: next_s.rdata = s.target;
        OFS_PRESCALE: next_s.rdata = s.pre_target;
        OFS_STATUS: next_s.rdata = {4'h0, bat, s.wd_ok, s.pf_done, s.flag};
        OFS_MAIN: next_s.rdata = s.main_count;
        OFS_PRE: next_s.rdata = s.pre_count;
        default: next_s.rdata = 8'h00;
      endcase
    end
    if (!s.ctrl.en) begin
      // Disabled: counters to defaults, flag untouched
      next_s.main_count = MAIN_RST; // RQ19 RQ17
      next_s.pre_count = PRE_RST; // RQ19
      next_s.in_pulse = 1'b0;
      next_s.in_pause = 1'b0;
      next_s.pf_done = 1'b0; // RQ15
      next_s.pf_run = 1'b0;
      next_s.wd_ok = 1'b0;
      next_s.irq_n = 1'b1;
    end else if (s.ctrl.mode == WPT_WATCHDOG) begin
      if (en_rise) begin
        // Arm only with a usable target
        next_s.wd_ok = s.target != 8'h00; // RQ6
        next_s.main_count = ONE; // RQ5
        next_s.pre_count = PRE_RST;
      end else if (!wd_act) begin
        // Held off: clock select zero or bad target
        next_s.irq_n = 1'b1; // RQ3
        next_s.in_pulse = 1'b0;
        next_s.in_pause = 1'b0;
      end else if (start_detect) begin
        // Bus activity: fresh cycle
        next_s.main_count = ONE; // RQ1
        next_s.pre_count = PRE_RST; // RQ1
        next_s.in_pulse = 1'b0;
        next_s.in_pause = 1'b0;
        next_s.irq_n = 1'b1;
      end else begin
        // Pulse window timing
        if (s.in_pulse || s.in_pause) begin
          next_s.pulse_cnt = s.pulse_cnt + 1'b1;
          if (s.pulse_cnt >= pmax) begin
            next_s.in_pulse = 1'b0; // RQ9
            next_s.in_pause = 1'b0; // RQ10
            next_s.irq_n = 1'b1; // RQ2
          end
        end
        // Prescaler and main count, frozen in remainder
        if (tick && !s.in_pause) begin
          if (ovf) begin
            next_s.pre_count = PRE_RST; // RQ7
            if (s.in_pulse && s.pulse_cnt < pmax) begin
              // Pulse ends after one prescale span
              next_s.in_pulse = 1'b0; // RQ9
              next_s.in_pause = 1'b1; // RQ10
              next_s.irq_n = 1'b1;
            end
            if (s.main_count >= s.target) begin
              // Expiry: flag, pulse, automatic restart
              flag_set = 1'b1; // RQ2
              next_s.main_count = ONE; // RQ8
              next_s.in_pulse = 1'b1;
              next_s.in_pause = 1'b0;
              next_s.pulse_cnt = '0;
              next_s.irq_n = !s.ctrl.oe; // RQ2
            end else begin
              next_s.main_count = s.main_count + ONE; // RQ7
            end
          end else begin
            next_s.pre_count = s.pre_count + ONE; // RQ7
          end
        end
      end
    end else begin
      // Power fail mode
      if (bat_rise || (en_rise && bat)) begin
        // Battery entry, or re-enable while already on battery
        next_s.pf_run = 1'b1; // RQ12 RQ15
        if (s.main_count == MAIN_RST && s.ctrl.tcs != TCS_OFF) begin
          // No load while the mode is held off by select zero
          next_s.main_count = ONE; // RQ12
          next_s.pre_count = PRE_RST;
        end
      end else if (bat_fall) begin
        next_s.pf_run = 1'b0; // RQ16
      end
      if (s.pf_done && flag_clr) begin
        // Flag cleared by software: restart
        next_s.pf_done = 1'b0; // RQ15
        next_s.main_count = ONE; // RQ15
        next_s.pre_count = PRE_RST;
        next_s.irq_n = 1'b1; // RQ15
      end else if (pf_act && tick) begin
        if (ovf) begin
          next_s.pre_count = PRE_RST; // RQ7
          next_s.main_count = s.main_count + ONE;
          if (s.main_count + ONE == PF_LAST) begin
            // Single event regardless of pulse mode
            flag_set = 1'b1; // RQ13 RQ14
            next_s.pf_done = 1'b1; // RQ14
            next_s.irq_n = !s.ctrl.oe; // RQ14
          end
        end else begin
          next_s.pre_count = s.pre_count + ONE; // RQ7
        end
      end
    end
    // Status flag: set beats clear
    if (flag_set) begin
      next_s.flag = 1'b1;
    end else if (flag_clr) begin
      next_s.flag = 1'b0; // RQ15
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.pre_count <= PRE_RST;
      s.irq_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign timer_irq_n = s.irq_n;

  // Checks on timer behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic [PULSE_W-1:0] low_cnt; // Length of current low in watchdog mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= '0;
    end else if (!s.irq_n && s.ctrl.mode == WPT_WATCHDOG) begin
      low_cnt <= low_cnt + 1'b1;
    end else begin
      low_cnt <= '0;
    end
  end

  AST_WD_START: assert property (wd_act && start_detect |=> // RQ1
    s.main_count == ONE && s.pre_count == PRE_RST)
    else $error("start did not restart watchdog");
  AST_WD_EXPIRE: assert property ($rose(s.in_pulse) |-> s.flag && // RQ2
    s.main_count == ONE && s.irq_n == !s.ctrl.oe)
    else $error("watchdog expiry without flag or restart");
  AST_PULSE_CAP: assert property (low_cnt <= PULSE_W'(PULSE_MAX)) // RQ9
    else $error("watchdog pulse longer than limit");
  AST_TCS_OFF: assert property (s.ctrl.en && s.en_q && s.ctrl.tcs == TCS_OFF && // RQ3
    !bus.wr ##1 s.ctrl.en |-> $stable(s.main_count) && $stable(s.pre_count))
    else $error("counting with clock select zero");
  AST_EN_LOAD: assert property (en_rise && s.ctrl.mode == WPT_WATCHDOG && // RQ5
    s.target != 8'h00 |=> s.main_count == ONE && s.wd_ok)
    else $error("enable did not load one");
  AST_BAD_TARGET: assert property (en_rise && s.target == 8'h00 |=> // RQ6
    !s.wd_ok ##1 (!s.wd_ok || !s.en_q))
    else $error("watchdog armed with zero target");
  AST_PRE_NONZERO: assert property (s.pre_count != 8'h00) // RQ7
    else $error("prescale count reached zero");
  AST_PF_EXPIRE: assert property ($rose(s.pf_done) |-> // RQ13
    s.main_count == PF_LAST && s.flag)
    else $error("power fail expiry at wrong count");
  AST_PF_STOP: assert property (s.pf_done && s.ctrl.en ##1 s.pf_done |-> // RQ14
    $stable(s.main_count))
    else $error("power fail count moved after expiry");
  AST_PF_KEEP: assert property (s.ctrl.mode == WPT_POWERFAIL && s.ctrl.en && // RQ16
    !bat && s.en_q && !bus.wr |=> $stable(s.main_count))
    else $error("power fail count lost on main supply");
  AST_DISABLE: assert property (!s.ctrl.en |=> s.main_count == MAIN_RST && // RQ19
    s.pre_count == PRE_RST && s.irq_n)
    else $error("disable did not restore defaults");

  COV_WD_EXPIRE: cover property ($rose(s.in_pulse));
  COV_WD_PAUSE: cover property ($rose(s.in_pause));
  COV_PF_EXPIRE: cover property ($rose(s.pf_done));
  COV_PF_RESTART: cover property (s.pf_done && flag_clr);
endmodule

// file: hdl/wpt_pkg.sv
// Package with constants, register map and state types of the watchdog/power-fail timer
// Notes on behaviour
// RQ1: Watchdog restarts count on every bus START
// RQ2: Watchdog expiry sets flag, pulses irq low
// RQ3: Watchdog idle when clock select is zero
// RQ4: Power fail idle when clock select zero
// RQ5: Watchdog enable loads main count with one
// RQ6: Zero target at enable keeps watchdog off
// RQ7: Prescaler wraps to one, bumps main count
// RQ8: Watchdog always restarts after each expiry
// RQ9: Interval target spans, pulse one span capped
// RQ10: Short pulse remainder delays next interval
// RQ11: Zero prescale target uses default, 100Hz=10ms
// RQ12: Power fail counting starts on battery entry
// RQ13: Power fail expires at count FFh only
// RQ14: Power fail expiry holds irq, stops count
// RQ15: Flag clear restarts; enable toggle keeps flag
// RQ16: Count kept across return to main supply
// RQ17: Retained count cleared only by disable
// RQ18: Host should enable irq pin for watchdog
// RQ19: Disable sets main to zero, prescale one
// RQ20: Prescale overflows at target or default
// RQ21: Default prescale counts are design parameters
package wpt_pkg;
  // Clock figures
  localparam int CLK_PERIOD_NS = 100;
  // Tick periods per clock select code
  localparam int TICK1_NS = 244000;
  localparam int TICK2_NS = 1000000000;
  localparam int TICK3_NS = 10000000;
  localparam int TICK1_CYC = TICK1_NS / CLK_PERIOD_NS;
  localparam int TICK2_CYC = TICK2_NS / CLK_PERIOD_NS;
  localparam int TICK3_CYC = TICK3_NS / CLK_PERIOD_NS;
  // Longest interrupt pulse
  localparam int PULSE_MAX_NS = 210000000;
  localparam int PULSE_MAX_CYC = PULSE_MAX_NS / CLK_PERIOD_NS;
  // Default prescale counts per clock select code
  localparam logic [7:0] DEF_PRE1 = 8'h15;
  localparam logic [7:0] DEF_PRE2 = 8'h01;
  localparam logic [7:0] DEF_PRE3 = 8'h15;
  // Count limits and reset values
  localparam logic [7:0] PF_LAST = 8'hff;
  localparam logic [7:0] MAIN_RST = 8'h00;
  localparam logic [7:0] PRE_RST = 8'h01;
  localparam logic [7:0] ONE = 8'h01;
  localparam logic [1:0] TCS_OFF = 2'h0;
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TARGET = 8'h01;
  localparam logic [7:0] OFS_PRESCALE = 8'h02;
  localparam logic [7:0] OFS_STATUS = 8'h03;
  localparam logic [7:0] OFS_MAIN = 8'h04;
  localparam logic [7:0] OFS_PRE = 8'h05;
  // Control field positions
  localparam int CTL_EN = 0;
  localparam int CTL_MODE = 1;
  localparam int CTL_OE = 2;
  localparam int CTL_PMS = 3;
  localparam int CTL_TCS = 4;
  // Status field positions
  localparam int STS_FLAG = 0;
  // Counter widths
  localparam int DIV_W = 24;
  localparam int PULSE_W = 24;

  // Timer mode
  typedef enum logic {
    WPT_WATCHDOG = 1'b0,
    WPT_POWERFAIL = 1'b1
  } wpt_mode_e;

  // Software control fields
  typedef struct packed {
    logic [1:0] tcs;
    logic pms;
    logic oe;
    wpt_mode_e mode;
    logic en;
  } wpt_ctrl_s;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wpt_bus_s;

  // Whole timer state
  typedef struct packed {
    wpt_ctrl_s ctrl;
    logic [7:0] target;
    logic [7:0] pre_target;
    logic [7:0] main_count;
    logic [7:0] pre_count;
    logic [PULSE_W-1:0] pulse_cnt;
    logic in_pulse;
    logic in_pause;
    logic wd_ok;
    logic pf_run;
    logic pf_done;
    logic flag;
    logic irq_n;
    logic en_q;
    logic bat_q;
    logic [7:0] rdata;
  } wpt_state_s;

  // Synchroniser state
  typedef struct packed {
    logic meta;
    logic sync;
  } wpt_sync_s;
endpackage

// file: hdl/wpt_sync2.sv
// Two-stage synchroniser for an asynchronous pin
`timescale 1ns/100ps
module wpt_sync2 import wpt_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  wpt_sync_s s; // Stage registers
  wpt_sync_s next_s; // Next stage values

  // Shift pin through two stages
  always_comb begin
    next_s.meta = din;
    next_s.sync = s.meta;
  end

  // Register stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.sync;
endmodule

// file: hdl/wpt_tick_gen.sv
// Tick divider: one-cycle enable at the selected timer rate
`timescale 1ns/100ps
module wpt_tick_gen import wpt_pkg::*; #(
  parameter int DIV1 = TICK1_CYC,
  parameter int DIV2 = TICK2_CYC,
  parameter int DIV3 = TICK3_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] sel,
  output logic tick
);
  logic [DIV_W-1:0] cnt; // Cycle counter
  logic [DIV_W-1:0] next_cnt; // Next counter value
  logic [DIV_W-1:0] last; // Terminal count of chosen rate

  // Pick terminal count, wrap counter
  always_comb begin
    unique case (sel)
      2'h1: last = DIV_W'(DIV1 - 1);
      2'h2: last = DIV_W'(DIV2 - 1);
      2'h3: last = DIV_W'(DIV3 - 1);
      default: last = '0;
    endcase
    if (sel == TCS_OFF || cnt >= last) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + 1'b1;
    end
  end

  // Counter register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // Tick on terminal count
  assign tick = (sel != TCS_OFF) && (cnt >= last);
endmodule

// file: dv/wpt_host_mon.sv
// Host-side monitor of the timer interrupt pin
`timescale 1ns/100ps
module wpt_host_mon (
  input wire logic clk,
  input wire logic timer_irq_n,
  output int falls,
  output int last_low
);
  int cnt; // Low cycles of the current pulse
  logic prev; // Pin seen high last cycle
  // Start with no pulses seen
  initial begin
    falls = 0;
    last_low = 0;
    cnt = 0;
    prev = 1'b1;
  end
  // Pin is the dependable sign, so count falls and widths here
  always @(posedge clk) begin
    if (timer_irq_n === 1'b0) begin
      if (prev) falls <= falls + 1;
      cnt <= cnt + 1;
    end else if (!prev) begin
      last_low <= cnt;
      cnt <= 0;
    end
    prev <= (timer_irq_n !== 1'b0);
  end
endmodule

// file: dv/wpt_timer_tb_top.sv
// Testbench of the watchdog and power-fail timer
`timescale 1ns/100ps
module wpt_timer_tb_top import wpt_pkg::*; ();
  logic clk, rst_n, wr, rd, start_detect, on_battery;
  logic [7:0] addr, wdata, d;
  wire logic [7:0] rdata;
  wire logic timer_irq_n;
  int falls, last_low, err_count, checked, n;
  // Short counts keep the run brief; default prescale kept
  wpt_timer #(.DIV1(4), .DIV2(8), .DIV3(6), .PULSE_MAX(40)) dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .start_detect(start_detect), .on_battery(on_battery),
    .timer_irq_n(timer_irq_n));
  wpt_host_mon host (.clk(clk), .timer_irq_n(timer_irq_n), .falls(falls),
    .last_low(last_low));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end
  // One-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // One-cycle register read, data taken in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk1(input logic e, input logic g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // Cycles until the next falling edge of the pin, capped
  task automatic wait_fall(input int lim, output int c);
    int f;
    f = falls;
    c = 0;
    while (falls == f && c < lim) begin
      @(negedge clk);
      c++;
    end
  endtask
  // Reset state and an unmapped read
  task automatic t_reset;
    rd_reg(OFS_MAIN, d);
    chk8(MAIN_RST, d);
    rd_reg(OFS_PRE, d);
    chk8(PRE_RST, d);
    rd_reg(8'h07, d);
    chk8(8'h00, d);
    chk1(1'b1, timer_irq_n);
    $display("t_reset done");
  endtask
  // First interval, pulse width, remainder added to next interval
  task automatic t_wd_basic;
    wr_reg(OFS_TARGET, 8'h02);
    wr_reg(OFS_PRESCALE, 8'h01);
    wr_reg(OFS_CTRL, 8'h15);
    wait_fall(60, n);
    chk1(1'b1, n >= 3 && n <= 12);
    wait_fall(80, n);
    chk1(1'b1, n >= 40 && n <= 52);
    chk1(1'b1, last_low >= 3 && last_low <= 5);
    rd_reg(OFS_STATUS, d);
    chk1(1'b1, d[STS_FLAG]);
    wr_reg(OFS_CTRL, 8'h00);
    $display("t_wd_basic done");
  endtask
  // Default prescale count for each nonzero clock select code (1, 2, 3)
  task automatic t_wd_defaults;
    int dv[3] = '{4, 8, 6};
    int df[3] = '{DEF_PRE1, DEF_PRE2, DEF_PRE3};
    int e;
    for (int k = 0; k < 3; k++) begin
      e = 2 * dv[k] * df[k];
      wr_reg(OFS_PRESCALE, 8'h00);
      wr_reg(OFS_CTRL, {2'b00, 2'(k + 1), 4'h5});
      wait_fall(400, n);
      chk1(1'b1, n >= e - dv[k] - 2 && n <= e + 6);
      wr_reg(OFS_CTRL, 8'h00);
    end
    $display("t_wd_defaults done");
  endtask
  // START pulses keep the watchdog from expiring
  task automatic t_wd_start;
    int f;
    wr_reg(OFS_PRESCALE, 8'h10);
    wr_reg(OFS_CTRL, 8'h15);
    rd_reg(OFS_MAIN, d);
    chk8(ONE, d);
    f = falls;
    repeat (30) begin
      @(posedge clk);
      start_detect <= 1'b1;
      @(posedge clk);
      start_detect <= 1'b0;
      repeat (18) @(posedge clk);
    end
    chk8(8'(f), 8'(falls));
    wait_fall(200, n);
    chk1(1'b1, n < 200);
    wr_reg(OFS_CTRL, 8'h00);
    $display("t_wd_start done");
  endtask
  // Zero target and select code zero keep the watchdog off
  task automatic t_wd_off;
    wr_reg(OFS_PRESCALE, 8'h01);
    wr_reg(OFS_TARGET, 8'h00);
    wr_reg(OFS_CTRL, 8'h15);
    wr_reg(OFS_TARGET, 8'h02);
    wait_fall(60, n);
    chk1(1'b1, n == 60);
    wr_reg(OFS_CTRL, 8'h00);
    wr_reg(OFS_CTRL, 8'h05);
    wait_fall(60, n);
    chk1(1'b1, n == 60);
    wr_reg(OFS_CTRL, 8'h00);
    wr_reg(OFS_CTRL, 8'h15);
    wait_fall(60, n);
    chk1(1'b1, n < 60);
    wr_reg(OFS_CTRL, 8'h00);
    $display("t_wd_off done");
  endtask
  // Battery count, retention, expiry, clear and disable
  task automatic t_pf;
    logic [7:0] m;
    wr_reg(OFS_CTRL, 8'h17);
    repeat (20) @(posedge clk);
    rd_reg(OFS_MAIN, d);
    chk8(MAIN_RST, d);
    on_battery <= 1'b1;
    repeat (20) @(posedge clk);
    on_battery <= 1'b0;
    repeat (8) @(posedge clk);
    rd_reg(OFS_MAIN, m);
    chk1(1'b1, m != 8'h00);
    repeat (40) @(posedge clk);
    rd_reg(OFS_MAIN, d);
    chk8(m, d);
    on_battery <= 1'b1;
    wait_fall(1200, n);
    chk1(1'b1, n < 1200 && n > (254 - m) * 4 - 8);
    repeat (50) @(posedge clk);
    rd_reg(OFS_MAIN, d);
    chk8(PF_LAST, d);
    chk1(1'b0, timer_irq_n);
    wr_reg(OFS_STATUS, 8'h00);
    rd_reg(OFS_MAIN, d);
    chk1(1'b1, d == ONE || d == 8'h02);
    chk1(1'b1, timer_irq_n);
    wait_fall(1200, n);
    wr_reg(OFS_CTRL, 8'h16);
    rd_reg(OFS_MAIN, d);
    chk8(MAIN_RST, d);
    rd_reg(OFS_STATUS, d);
    chk1(1'b1, d[STS_FLAG]);
    chk1(1'b1, timer_irq_n);
    on_battery <= 1'b0;
    wr_reg(OFS_CTRL, 8'h07);
    on_battery <= 1'b1;
    repeat (40) @(posedge clk);
    rd_reg(OFS_MAIN, d);
    chk8(MAIN_RST, d);
    $display("t_pf done");
  endtask
  task automatic finish_test;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  initial begin
    #(CLK_PERIOD_NS * 12000);
    err_count++;
    finish_test();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    {wr, rd, start_detect, on_battery} = 4'h0;
    addr = 8'h00;
    wdata = 8'h00;
    err_count = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_wd_basic();
    t_wd_defaults();
    t_wd_start();
    t_wd_off();
    t_pf();
    finish_test();
  end
endmodule
